// File: hw/cpu_clear_call_decrement_ops.sv
/*
 Execution logic for clear-watchdog, call through accumulator, complement,
 clear file, clear accumulator, decrement and decrement-skip-if-zero.
 Assumes instructions arrive from program memory on the core clock, one per
 cycle while instr_ready_r is high, and that a return stack and watchdog
 counter outside take the push and clear pulses.
 The register port answers a read in the next cycle and never stalls;
 an instruction write to the same place wins over a port write.
*/
// Summary of operation
// - Clear watchdog zeroes counter and prescaler
// - Clear watchdog sets timeout and powerdown flags
// - Call via accumulator pushes PC plus one
// - PC low from accumulator, high from latch
// - Call via accumulator: two cycles, flags kept
// - Complement file to destination, zero updated
// - Clear file zeroes register, sets zero
// - Decrement file to destination, zero updated
// - Clear accumulator zeroes it, sets zero
// - Decrement skip: zero result skips, flags kept
// - Taken skip executes no-op, two cycles
`timescale 1ns/10ps
`default_nettype none

module cpu_clear_call_decrement_ops (
   input wire logic clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire cpu_ops_pkg::op_e instr_op,
   input wire logic [cpu_ops_pkg::FILE_AW-1:0] instr_file,
   input wire logic instr_dest,
   input wire logic watchdog_timeout_evt,
   input wire logic sleep_evt,
   input wire logic [cpu_ops_pkg::REG_AW-1:0] reg_addr,
   input wire logic [cpu_ops_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [cpu_ops_pkg::DATA_W-1:0] reg_rdata_r,
   output logic instr_ready_r,
   output logic [cpu_ops_pkg::PC_W-1:0] pc_r,
   output logic stack_push_r,
   output logic [cpu_ops_pkg::PC_W-1:0] stack_top_r,
   output logic watchdog_clear_r,
   output logic prescaler_clear_r,
   output logic zero_flag_r,
   output logic timeout_flag_r,
   output logic powerdown_flag_r
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      st_exec,
      st_call_wait,
      st_skip_nop
   } state_e;

   state_e state_r;
   state_e state_nxt;
   logic [cpu_ops_pkg::DATA_W-1:0] file_r [cpu_ops_pkg::FILE_DEPTH];
   logic [cpu_ops_pkg::DATA_W-1:0] acc_r;
   logic [cpu_ops_pkg::LATCH_W-1:0] latch_r;
   logic exec;
   logic [cpu_ops_pkg::DATA_W-1:0] operand;
   logic [cpu_ops_pkg::DATA_W-1:0] result;
   logic result_zero;
   logic alu_op;
   logic file_we;
   logic acc_we;
   logic zero_we;
   logic zero_nxt;
   logic skip;
   logic bus_file_we;
   // Decoded strobes; the call and clear-watchdog ones are shared by several registers
   logic is_call;
   logic is_clear_watchdog;
   logic acc_bus_we;
   logic latch_bus_we;
   logic status_bus_we;

   // ----------------------------------------------------------------
   // Decode and datapath
   // ----------------------------------------------------------------
   // Instructions offered during the second cycle are not taken
   assign exec = instr_valid && (state_r == st_exec);
   assign operand = file_r[instr_file];

   always_comb begin
      result = operand;
      alu_op = 1'b0;
      case (instr_op)
         cpu_ops_pkg::complement_file_op: begin
            result = ~operand;
            alu_op = 1'b1;
         end
         cpu_ops_pkg::decrement_file_op, cpu_ops_pkg::decrement_skip_zero_op: begin
            result = operand - cpu_ops_pkg::ONE;
            alu_op = 1'b1;
         end
         cpu_ops_pkg::clear_file_op: begin
            result = cpu_ops_pkg::FILE_RESET;
         end
         default: begin
            result = operand;
         end
      endcase
   end

   assign result_zero = (result == cpu_ops_pkg::FILE_RESET);
   // Destination bit: 1 back to file, 0 to accumulator
   assign file_we = exec && ((instr_op == cpu_ops_pkg::clear_file_op) || (alu_op && instr_dest));
   assign acc_we = exec && alu_op && !instr_dest;
   assign skip = exec && (instr_op == cpu_ops_pkg::decrement_skip_zero_op) && result_zero;
   assign is_call = exec && (instr_op == cpu_ops_pkg::call_via_accumulator_op);
   assign is_clear_watchdog = exec && (instr_op == cpu_ops_pkg::clear_watchdog_op);

   // Register port write decode
   assign bus_file_we = reg_wr && (reg_addr <= cpu_ops_pkg::FILE_LAST_ADDR);
   assign acc_bus_we = reg_wr && (reg_addr == cpu_ops_pkg::ACC_ADDR);
   assign latch_bus_we = reg_wr && (reg_addr == cpu_ops_pkg::LATCH_ADDR);
   assign status_bus_we = reg_wr && (reg_addr == cpu_ops_pkg::STATUS_ADDR);

   always_comb begin
      zero_we = 1'b0;
      zero_nxt = zero_flag_r;
      if (exec) begin
         case (instr_op)
            cpu_ops_pkg::complement_file_op, cpu_ops_pkg::decrement_file_op: begin
               zero_we = 1'b1;
               zero_nxt = result_zero;
            end
            cpu_ops_pkg::clear_file_op, cpu_ops_pkg::clear_accumulator_op: begin
               zero_we = 1'b1;
               zero_nxt = 1'b1;
            end
            default: begin
               zero_we = 1'b0; // Call and skip leave status alone
            end
         endcase
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_exec: begin
            if (exec && instr_op == cpu_ops_pkg::call_via_accumulator_op) begin
               state_nxt = st_call_wait;
            end else if (skip) begin
               state_nxt = st_skip_nop;
            end
         end
         st_call_wait, st_skip_nop: begin
            state_nxt = st_exec;
         end
         default: begin
            state_nxt = st_exec;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Ready mirrors the next state, so it is a plain flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= st_exec;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         instr_ready_r <= 1'b1;
      end else begin
         instr_ready_r <= (state_nxt == st_exec);
      end
   end

   // ----------------------------------------------------------------
   // Program counter and return stack push
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pc_r <= cpu_ops_pkg::PC_RESET;
      end else if (is_call) begin
         // Target stands through the second cycle of the call
         pc_r <= {latch_r, acc_r};
      end else if (exec || state_r == st_skip_nop) begin
         // Discarded word still advances the fetch address
         pc_r <= pc_r + cpu_ops_pkg::PC_STEP;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stack_push_r <= 1'b0;
      end else begin
         stack_push_r <= is_call;
      end
   end

   // Return address holds after the push for the stack to copy
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stack_top_r <= cpu_ops_pkg::PC_RESET;
      end else if (is_call) begin
         stack_top_r <= pc_r + cpu_ops_pkg::PC_STEP;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog and status flags
   // ----------------------------------------------------------------
   // Both pulses come from one decode, one flop each
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         watchdog_clear_r <= 1'b0;
      end else begin
         watchdog_clear_r <= is_clear_watchdog;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prescaler_clear_r <= 1'b0;
      end else begin
         prescaler_clear_r <= is_clear_watchdog;
      end
   end

   // Set by the instruction wins over an event clearing in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timeout_flag_r <= cpu_ops_pkg::TIMEOUT_RESET;
      end else if (is_clear_watchdog) begin
         timeout_flag_r <= 1'b1;
      end else if (watchdog_timeout_evt) begin
         timeout_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         powerdown_flag_r <= cpu_ops_pkg::POWERDOWN_RESET;
      end else if (is_clear_watchdog) begin
         powerdown_flag_r <= 1'b1;
      end else if (sleep_evt) begin
         powerdown_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         zero_flag_r <= cpu_ops_pkg::ZERO_RESET;
      end else if (zero_we) begin
         zero_flag_r <= zero_nxt;
      end else if (status_bus_we) begin
         zero_flag_r <= reg_wdata[cpu_ops_pkg::ZERO_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Accumulator, latch and file registers
   // ----------------------------------------------------------------
   // Instruction writes take priority over the register port
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_r <= cpu_ops_pkg::ACC_RESET;
      end else if (exec && instr_op == cpu_ops_pkg::clear_accumulator_op) begin
         acc_r <= cpu_ops_pkg::ACC_RESET;
      end else if (acc_we) begin
         acc_r <= result;
      end else if (acc_bus_we) begin
         acc_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         latch_r <= cpu_ops_pkg::LATCH_RESET;
      end else if (latch_bus_we) begin
         latch_r <= reg_wdata[cpu_ops_pkg::LATCH_W-1:0];
      end
   end

   for (genvar i = 0; i < cpu_ops_pkg::FILE_DEPTH; i++) begin : g_file
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            file_r[i] <= cpu_ops_pkg::FILE_RESET;
         end else if (file_we && instr_file == i[cpu_ops_pkg::FILE_AW-1:0]) begin
            file_r[i] <= result;
         end else if (bus_file_we && reg_addr[cpu_ops_pkg::FILE_AW-1:0] == i[cpu_ops_pkg::FILE_AW-1:0]) begin
            file_r[i] <= reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register port read
   // ----------------------------------------------------------------
   // Read data valid only in the cycle after the strobe; zero otherwise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_r <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_addr <= cpu_ops_pkg::FILE_LAST_ADDR) begin
         reg_rdata_r <= file_r[reg_addr[cpu_ops_pkg::FILE_AW-1:0]];
      end else begin
         case (reg_addr)
            cpu_ops_pkg::ACC_ADDR: begin
               reg_rdata_r <= acc_r;
            end
            cpu_ops_pkg::LATCH_ADDR: begin
               reg_rdata_r <= {1'b0, latch_r};
            end
            cpu_ops_pkg::STATUS_ADDR: begin
               reg_rdata_r <= {3'h0, timeout_flag_r, powerdown_flag_r, zero_flag_r, 2'h0};
            end
            // Halves are separate reads; a running counter can tear
            cpu_ops_pkg::PC_LOW_ADDR: begin
               reg_rdata_r <= pc_r[7:0];
            end
            cpu_ops_pkg::PC_HIGH_ADDR: begin
               reg_rdata_r <= {1'b0, pc_r[14:8]};
            end
            default: begin
               reg_rdata_r <= 8'h00;
            end
         endcase
      end
   end

endmodule : cpu_clear_call_decrement_ops

`default_nettype wire

// File: hw/cpu_ops_pkg.sv
/*
 Constants, operation codes and register map shared by the clear, call and
 decrement execution block.
 Assumes a single 40 MHz core clock and an active-low asynchronous reset.
*/
package cpu_ops_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FILE_AW = 7;
   localparam int FILE_DEPTH = 128;
   localparam int PC_W = 15;
   localparam int LATCH_W = 7;
   localparam int REG_AW = 8;

   // ----------------------------------------------------------------
   // Operations on the instruction port
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      no_op,
      clear_watchdog_op,
      call_via_accumulator_op,
      complement_file_op,
      clear_file_op,
      decrement_file_op,
      clear_accumulator_op,
      decrement_skip_zero_op
   } op_e;

   // ----------------------------------------------------------------
   // Register port map; file registers sit at 8'h00 to 8'h7f
   // ----------------------------------------------------------------
   localparam logic [REG_AW-1:0] FILE_LAST_ADDR = 8'h7f;
   localparam logic [REG_AW-1:0] ACC_ADDR = 8'h80;
   localparam logic [REG_AW-1:0] LATCH_ADDR = 8'h81;
   localparam logic [REG_AW-1:0] STATUS_ADDR = 8'h82;
   localparam logic [REG_AW-1:0] PC_LOW_ADDR = 8'h83;
   localparam logic [REG_AW-1:0] PC_HIGH_ADDR = 8'h84;

   // ----------------------------------------------------------------
   // Status field positions and reset values
   // ----------------------------------------------------------------
   localparam int ZERO_BIT = 2;
   localparam int POWERDOWN_BIT = 3;
   localparam int TIMEOUT_BIT = 4;

   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;
   localparam logic [LATCH_W-1:0] LATCH_RESET = 7'h00;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic TIMEOUT_RESET = 1'b1;
   localparam logic POWERDOWN_RESET = 1'b1;
   localparam logic [DATA_W-1:0] ONE = 8'h01;
   localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

endpackage : cpu_ops_pkg

// File: testbench/cpu_clear_call_decrement_ops_tb_top.sv
/* Directed bench for the clear, call and decrement execution block.
   Assumes the property checker is bound in; clock 40 MHz. */
`timescale 1ns/10ps
`default_nettype none
module cpu_clear_call_decrement_ops_tb_top;
   // ------------------------------------------------
   // Signals
   // ------------------------------------------------
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   cpu_ops_pkg::op_e instr_op = cpu_ops_pkg::no_op;
   logic [6:0] instr_file = 7'h00;
   logic instr_dest = 1'b0;
   logic watchdog_timeout_evt = 1'b0;
   logic sleep_evt = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata_r;
   logic instr_ready_r;
   logic [14:0] stack_top_r;
   int err_total = 0;
   int checks_done = 0;

   always #12.5 clk = ~clk;

   cpu_clear_call_decrement_ops dut (.clk(clk), .resetn(resetn), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_file(instr_file), .instr_dest(instr_dest),
      .watchdog_timeout_evt(watchdog_timeout_evt), .sleep_evt(sleep_evt), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .instr_ready_r(instr_ready_r), .pc_r(), .stack_push_r(), .stack_top_r(stack_top_r),
      .watchdog_clear_r(), .prescaler_clear_r(), .zero_flag_r(), .timeout_flag_r(),
      .powerdown_flag_r());

   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic complete_run;
      if (err_total == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string n, input logic [14:0] got, input logic [14:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask : chk

   // Strobe left high; the next task lowers it, so back-to-back writes hold it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      instr_valid <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      instr_valid <= 1'b0;
      reg_wr <= 1'b0;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {7'h00, reg_rdata_r & m}, {7'h00, e});
      @(posedge clk);
   endtask : rd

   // Valid stays up so a following op lands back to back, even in a stall
   task automatic ex(input cpu_ops_pkg::op_e op, input logic [6:0] f, input logic d);
      logic r;
      int i;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      instr_op <= op;
      instr_file <= f;
      instr_dest <= d;
      instr_valid <= 1'b1;
      for (i = 0; i < 8; i++) begin
         #1;
         r = instr_ready_r;
         @(posedge clk);
         if (r === 1'b1) return;
      end
      err_total++;
      complete_run();
   endtask : ex

   // ------------------------------------------------
   // Sequence
   // ------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h82, 8'h18, 8'h1c);
      wr(8'h05, 8'h01);
      wr(8'h07, 8'h02);
      wr(8'h81, 8'h12);
      ex(cpu_ops_pkg::decrement_file_op, 7'h05, 1'b1);
      rd(8'h05, 8'h00);
      rd(8'h82, 8'h1c, 8'h1c);
      ex(cpu_ops_pkg::complement_file_op, 7'h05, 1'b0);
      rd(8'h80, 8'hff);
      rd(8'h05, 8'h00);
      rd(8'h82, 8'h18, 8'h1c);
      ex(cpu_ops_pkg::complement_file_op, 7'h05, 1'b1);
      rd(8'h05, 8'hff);
      ex(cpu_ops_pkg::decrement_file_op, 7'h05, 1'b0);
      rd(8'h80, 8'hfe);
      rd(8'h05, 8'hff);
      ex(cpu_ops_pkg::decrement_skip_zero_op, 7'h07, 1'b1);
      ex(cpu_ops_pkg::decrement_skip_zero_op, 7'h07, 1'b0);
      rd(8'h07, 8'h01);
      rd(8'h80, 8'h00);
      rd(8'h82, 8'h18, 8'h1c);
      rd(8'h83, 8'h07);
      ex(cpu_ops_pkg::clear_file_op, 7'h07, 1'b1);
      rd(8'h07, 8'h00);
      rd(8'h82, 8'h1c, 8'h1c);
      wr(8'h80, 8'h55);
      wr(8'h82, 8'h00);
      ex(cpu_ops_pkg::clear_accumulator_op, 7'h00, 1'b1);
      rd(8'h80, 8'h00);
      rd(8'h82, 8'h1c, 8'h1c);
      wr(8'h80, 8'h40);
      ex(cpu_ops_pkg::call_via_accumulator_op, 7'h00, 1'b0);
      ex(cpu_ops_pkg::decrement_file_op, 7'h05, 1'b1);
      chk("stack_top", stack_top_r, 15'h000a);
      rd(8'h83, 8'h41);
      rd(8'h84, 8'h12);
      rd(8'h05, 8'hfe);
      watchdog_timeout_evt <= 1'b1;
      sleep_evt <= 1'b1;
      @(posedge clk);
      watchdog_timeout_evt <= 1'b0;
      sleep_evt <= 1'b0;
      rd(8'h82, 8'h00, 8'h1c);
      ex(cpu_ops_pkg::clear_watchdog_op, 7'h00, 1'b0);
      rd(8'h82, 8'h18, 8'h1c);
      // Set by the instruction wins over a clearing event
      watchdog_timeout_evt <= 1'b1;
      sleep_evt <= 1'b1;
      ex(cpu_ops_pkg::clear_watchdog_op, 7'h00, 1'b0);
      watchdog_timeout_evt <= 1'b0;
      sleep_evt <= 1'b0;
      rd(8'h82, 8'h18, 8'h1c);
      wr(8'h7f, 8'h01);
      ex(cpu_ops_pkg::decrement_file_op, 7'h7f, 1'b1);
      rd(8'h7f, 8'h00);
      rd(8'h80, 8'h40);
      // Unmapped place must neither store nor answer
      wr(8'h90, 8'h77);
      rd(8'h90, 8'h00);
      rd(8'h10, 8'h00);
      complete_run();
   end
endmodule : cpu_clear_call_decrement_ops_tb_top
`default_nettype wire

// File: testbench/cpu_ops_properties.sv
/* Concurrent checks for the clear, call and decrement execution block.
   Assumes it is bound to the block top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module cpu_ops_properties (
   input wire logic clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire cpu_ops_pkg::op_e instr_op,
   input wire logic instr_ready_r,
   input wire logic [cpu_ops_pkg::PC_W-1:0] pc_r,
   input wire logic stack_push_r,
   input wire logic [cpu_ops_pkg::PC_W-1:0] stack_top_r,
   input wire logic watchdog_clear_r,
   input wire logic prescaler_clear_r,
   input wire logic zero_flag_r,
   input wire logic timeout_flag_r,
   input wire logic powerdown_flag_r
);
   // ------------------------------------------------
   // Taken instructions
   // ------------------------------------------------
   logic take, do_wdt, do_call, do_skip, do_clr;
   assign take = instr_valid && instr_ready_r;
   assign do_wdt = take && instr_op == cpu_ops_pkg::clear_watchdog_op;
   assign do_call = take && instr_op == cpu_ops_pkg::call_via_accumulator_op;
   assign do_skip = take && instr_op == cpu_ops_pkg::decrement_skip_zero_op;
   assign do_clr = take && (instr_op == cpu_ops_pkg::clear_file_op || instr_op == cpu_ops_pkg::clear_accumulator_op);

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   a_wdt_clear_pulse: assert property (do_wdt |=> watchdog_clear_r && prescaler_clear_r ##1 ((!watchdog_clear_r && !prescaler_clear_r) || $past(do_wdt)))
      else $error("watchdog clear pulse wrong");
   a_wdt_sets_flags: assert property (do_wdt |=> timeout_flag_r && powerdown_flag_r)
      else $error("watchdog clear left a flag low");
   a_call_push: assert property (do_call |=> stack_push_r && stack_top_r == $past(pc_r) + 15'h0001)
      else $error("call return address wrong");
   a_call_stall: assert property (do_call |=> !instr_ready_r ##1 (instr_ready_r && !stack_push_r))
      else $error("call not two cycles");
   a_call_flags_kept: assert property (do_call |=> $stable(zero_flag_r) && $stable(timeout_flag_r) && $stable(powerdown_flag_r))
      else $error("call changed a flag");
   a_clear_sets_zero: assert property (do_clr |=> zero_flag_r)
      else $error("clear left zero flag low");
   a_skip_flag_kept: assert property (do_skip |=> $stable(zero_flag_r))
      else $error("skip changed zero flag");
   a_stall_one_cycle: assert property (!instr_ready_r |=> instr_ready_r)
      else $error("stall longer than one cycle");
   a_stall_cause: assert property ($fell(instr_ready_r) |-> $past(do_call) || $past(do_skip))
      else $error("stall without call or skip");
endmodule : cpu_ops_properties

bind cpu_clear_call_decrement_ops cpu_ops_properties u_props (.clk(clk), .resetn(resetn),
   .instr_valid(instr_valid), .instr_op(instr_op), .instr_ready_r(instr_ready_r), .pc_r(pc_r),
   .stack_push_r(stack_push_r), .stack_top_r(stack_top_r), .watchdog_clear_r(watchdog_clear_r),
   .prescaler_clear_r(prescaler_clear_r), .zero_flag_r(zero_flag_r), .timeout_flag_r(timeout_flag_r),
   .powerdown_flag_r(powerdown_flag_r));
`default_nettype wire
